//--- hdl/mdr_pkg.sv
package mdr_pkg;

    // Array shape.
    localparam int unsigned NUM_GROUPS = 5;
    localparam int unsigned GROUP_SIZE = 8;
    localparam int unsigned NUM_CHANNELS = NUM_GROUPS * GROUP_SIZE;
    localparam int unsigned CHAN_W = 6;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned OFS_DAC_W = 14;
    localparam int unsigned CTRL_W = 3;

    // Register select codes on the command port.
    typedef enum logic [2:0] {
        MDR_SEL_DATA = 3'h0,
        MDR_SEL_GAIN = 3'h1,
        MDR_SEL_OFFSET = 3'h2,
        MDR_SEL_GROUP0_OFFSET_DAC = 3'h3,
        MDR_SEL_UPPER_GROUPS_OFFSET_DAC = 3'h4,
        MDR_SEL_CONTROL = 3'h5,
        MDR_SEL_GROUP = 3'h6,
        MDR_SEL_ALL_GROUPS = 3'h7
    } mdr_sel_t;

    // Control register fields.
    localparam int unsigned CTRL_BANK_BIT = 2;
    localparam int unsigned CTRL_THERM_BIT = 1;
    localparam int unsigned CTRL_PDOWN_BIT = 0;

    // Values after reset.
    localparam logic [15:0] INPUT_RST = 16'h1555;
    localparam logic [15:0] GAIN_RST = 16'h3FFF;
    localparam logic [15:0] OFFSET_RST = 16'h2000;
    localparam logic [15:0] CAL_RST = 16'h0000;
    localparam logic [15:0] DAC_RST = 16'h0000;
    localparam logic [13:0] OFS_DAC_RST = 14'h1555;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [7:0] GROUP_SEL_RST = 8'h00;

    // Calibration arithmetic.
    localparam logic [18:0] CAL_MID = 19'h08000;
    localparam logic [15:0] CAL_MAX = 16'hFFFF;

endpackage

//--- hdl/mdr_calibrator.sv
`timescale 1ns/100ps

// Shared gain and offset trim arithmetic, one instance for all channels.
module mdr_calibrator
(
    // Operands
    input wire logic [15:0] code_in,
    input wire logic [15:0] gain,
    input wire logic [15:0] offset,
    // Result
    output logic [15:0] code_out
);

    logic [16:0] gain_p1;
    logic [32:0] product;
    logic [18:0] sum;

    assign gain_p1 = {1'b0, gain} + 17'h00001;
    assign product = {17'h00000, code_in} * {16'h0000, gain_p1};
    // Signed 19-bit sum: product/2^16 + offset - 2^15.
    assign sum = {2'b00, product[32:16]} + {3'b000, offset} - mdr_pkg::CAL_MID;

    // Clamp to the unsigned range so the trim never wraps.
    assign code_out = sum[18] ? 16'h0000 :
                      (sum[17:16] != 2'b00) ? mdr_pkg::CAL_MAX : sum[15:0];

endmodule

//--- hdl/mdr_core.sv
`timescale 1ns/100ps

// What this block does
// - Forty channels in five groups of eight sharing group offset settings.
// - Each channel has input registers A and B, reset to 0x1555.
// - Each channel has a gain trim register, reset to 0x3FFF.
// - Each channel has an offset trim register, reset to 0x2000.
// - Calibrated A and B per channel hold trimmed results, not host accessible.
// - Final converter register loads only from calibrated A or B, no host access.
// - Two 14-bit offset converter registers reset 0x1555: group 0, groups 1-4.
// - Control bit 2 picks bank A (0) or B (1) for data writes.
// - Control bit 1 enables thermal shutdown when set.
// - Control bit 0 commands soft power-down when set, power-up when clear.
// - Control register resets to zero: bank A, shutdown off, powered up.
// - Per-group 8-bit select, reset zero, bit picks calibrated A or B.
// - Select bits 0 to 7 map to the group's channels 0 to 7.
// - Recompute calibrated A or B on input write or trim write with that bank.
// - While load input is low, all final registers load from selected calibrated.
module mdr_core #(
    parameter int unsigned NUM_GROUPS = mdr_pkg::NUM_GROUPS,
    parameter int unsigned GROUP_SIZE = mdr_pkg::GROUP_SIZE
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register command port
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [2:0] reg_sel,
    input wire logic [5:0] chan,
    input wire logic [15:0] wr_data,
    // Register read answer
    output logic [15:0] rd_data_r,
    output logic rd_valid_r,
    // Load pin
    input wire logic load_converters_n,
    // Converter side
    output logic [NUM_GROUPS*GROUP_SIZE*16-1:0] dac_code_r,
    output logic [13:0] group0_offset_dac_r,
    output logic [13:0] upper_groups_offset_dac_r,
    output logic thermal_shutdown_en_r,
    output logic soft_power_down_r
);

    localparam int unsigned NCH = NUM_GROUPS * GROUP_SIZE;

    // Register storage.
    logic [15:0] input_data_bank_a [NCH];
    logic [15:0] input_data_bank_b [NCH];
    logic [15:0] gain_trim [NCH];
    logic [15:0] offset_trim [NCH];
    logic [15:0] calibrated_output_a [NCH];
    logic [15:0] calibrated_output_b [NCH];
    logic [2:0] global_control_r;
    // Bit 8g+k steers channel k of group g.
    logic [NCH-1:0] bank_select_r;

    // Load pin synchroniser.
    logic ld_s1_r;
    logic ld_s2_r;

    // Recompute pipeline.
    logic calc_vld_r;
    logic calc_bank_r;
    logic [5:0] calc_chan_r;
    logic [15:0] calc_code;
    logic [15:0] calc_result;

    // Command decode.
    wire mdr_pkg::mdr_sel_t sel = mdr_pkg::mdr_sel_t'(reg_sel);
    wire chan_ok = {26'h0, chan} < NCH;
    wire bank_b = global_control_r[mdr_pkg::CTRL_BANK_BIT];
    wire wr_data_a = wr_en && chan_ok && sel == mdr_pkg::MDR_SEL_DATA && !bank_b;
    wire wr_data_b = wr_en && chan_ok && sel == mdr_pkg::MDR_SEL_DATA && bank_b;
    wire wr_gain = wr_en && chan_ok && sel == mdr_pkg::MDR_SEL_GAIN;
    wire wr_offset = wr_en && chan_ok && sel == mdr_pkg::MDR_SEL_OFFSET;
    wire wr_group0_offset_dac = wr_en && sel == mdr_pkg::MDR_SEL_GROUP0_OFFSET_DAC;
    wire wr_upper_groups_offset_dac = wr_en && sel == mdr_pkg::MDR_SEL_UPPER_GROUPS_OFFSET_DAC;
    wire wr_ctrl = wr_en && sel == mdr_pkg::MDR_SEL_CONTROL;
    wire grp_ok = {29'h0, chan[2:0]} < NUM_GROUPS;
    wire wr_group = wr_en && sel == mdr_pkg::MDR_SEL_GROUP && grp_ok;
    wire wr_all = wr_en && sel == mdr_pkg::MDR_SEL_ALL_GROUPS;
    wire calc_req = wr_data_a || wr_data_b || wr_gain || wr_offset;
    wire load_now = !ld_s2_r;

    // Read decode: calibrated and final registers have no select code.
    wire [15:0] rd_data_word = bank_b ? input_data_bank_b[chan] : input_data_bank_a[chan];
    wire [15:0] rd_group_word = {8'h00, bank_select_r[chan[2:0]*GROUP_SIZE +: 8]};
    wire [15:0] rd_mux =
        (sel == mdr_pkg::MDR_SEL_DATA && chan_ok) ? rd_data_word :
        (sel == mdr_pkg::MDR_SEL_GAIN && chan_ok) ? gain_trim[chan] :
        (sel == mdr_pkg::MDR_SEL_OFFSET && chan_ok) ? offset_trim[chan] :
        (sel == mdr_pkg::MDR_SEL_GROUP0_OFFSET_DAC) ? {2'b00, group0_offset_dac_r} :
        (sel == mdr_pkg::MDR_SEL_UPPER_GROUPS_OFFSET_DAC) ? {2'b00, upper_groups_offset_dac_r} :
        (sel == mdr_pkg::MDR_SEL_CONTROL) ? {13'h0000, global_control_r} :
        (sel == mdr_pkg::MDR_SEL_GROUP && grp_ok) ? rd_group_word : 16'h0000;

    // Trim arithmetic for the channel captured last cycle.
    assign calc_code = calc_bank_r ? input_data_bank_b[calc_chan_r]
                                   : input_data_bank_a[calc_chan_r];

    mdr_calibrator u_cal
    (
        .code_in(calc_code),
        .gain(gain_trim[calc_chan_r]),
        .offset(offset_trim[calc_chan_r]),
        .code_out(calc_result)
    );

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ld_s1_r <= 1'b1;
            ld_s2_r <= 1'b1;
        end
        else
        begin
            ld_s1_r <= load_converters_n;
            ld_s2_r <= ld_s1_r;
        end
    end

    // Per-channel input registers, one array per bank.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < NCH; i++)
                input_data_bank_a[i] <= mdr_pkg::INPUT_RST;
        end
        else if (wr_data_a)
            input_data_bank_a[chan] <= wr_data;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < NCH; i++)
                input_data_bank_b[i] <= mdr_pkg::INPUT_RST;
        end
        else if (wr_data_b)
            input_data_bank_b[chan] <= wr_data;
    end

    // Per-channel trim registers.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < NCH; i++)
                gain_trim[i] <= mdr_pkg::GAIN_RST;
        end
        else if (wr_gain)
            gain_trim[chan] <= wr_data;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < NCH; i++)
                offset_trim[i] <= mdr_pkg::OFFSET_RST;
        end
        else if (wr_offset)
            offset_trim[chan] <= wr_data;
    end

    // A trim write recomputes the bank that the control bit selects.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            calc_vld_r <= 1'b0;
            calc_bank_r <= 1'b0;
            calc_chan_r <= 6'h00;
        end
        else
        begin
            calc_vld_r <= calc_req;
            calc_bank_r <= bank_b;
            calc_chan_r <= chan;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < NCH; i++)
            begin
                calibrated_output_a[i] <= mdr_pkg::CAL_RST;
                calibrated_output_b[i] <= mdr_pkg::CAL_RST;
            end
        end
        else if (calc_vld_r)
        begin
            if (calc_bank_r)
                calibrated_output_b[calc_chan_r] <= calc_result;
            else
                calibrated_output_a[calc_chan_r] <= calc_result;
        end
    end

    // Final converter registers, one per channel.
    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : gen_dac
            always_ff @(posedge core_clk or posedge rst)
            begin
                if (rst)
                    dac_code_r[g*16 +: 16] <= mdr_pkg::DAC_RST;
                else if (load_now)
                    dac_code_r[g*16 +: 16] <= bank_select_r[g] ?
                        calibrated_output_b[g] : calibrated_output_a[g];
            end
        end
    endgenerate

    // Offset converter registers: group 0, then groups 1 to 4.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            group0_offset_dac_r <= mdr_pkg::OFS_DAC_RST;
        else if (wr_group0_offset_dac)
            group0_offset_dac_r <= wr_data[13:0];
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            upper_groups_offset_dac_r <= mdr_pkg::OFS_DAC_RST;
        else if (wr_upper_groups_offset_dac)
            upper_groups_offset_dac_r <= wr_data[13:0];
    end

    // Global control register.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            global_control_r <= mdr_pkg::CTRL_RST;
        else if (wr_ctrl)
            global_control_r <= wr_data[2:0];
    end

    // Group select registers; the all-groups command sets every bit alike.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            bank_select_r <= {NUM_GROUPS{mdr_pkg::GROUP_SEL_RST}};
        else if (wr_group)
            bank_select_r[chan[2:0]*GROUP_SIZE +: 8] <= wr_data[7:0];
        else if (wr_all)
            bank_select_r <= {NCH{wr_data[0]}};
    end

    // Control bits driven out to the analog section.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            thermal_shutdown_en_r <= 1'b0;
        else
            thermal_shutdown_en_r <= global_control_r[mdr_pkg::CTRL_THERM_BIT];
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            soft_power_down_r <= 1'b0;
        else
            soft_power_down_r <= global_control_r[mdr_pkg::CTRL_PDOWN_BIT];
    end

    // Read answer: the strobe is echoed one cycle later with the word.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            rd_valid_r <= 1'b0;
        else
            rd_valid_r <= rd_en;
    end

    // The word stays until the next read replaces it.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            rd_data_r <= 16'h0000;
        else if (rd_en)
            rd_data_r <= rd_mux;
    end

endmodule

//--- verif/mdr_core_sva.sv
`timescale 1ns/100ps
module mdr_core_chk #(
    parameter int unsigned NUM_GROUPS = 5,
    parameter int unsigned GROUP_SIZE = 8
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Command side
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [2:0] reg_sel,
    input wire logic [5:0] chan,
    input wire logic [15:0] wr_data,
    input wire logic load_converters_n,
    // Answers and outputs
    input wire logic [15:0] rd_data_r,
    input wire logic rd_valid_r,
    input wire logic [NUM_GROUPS*GROUP_SIZE*16-1:0] dac_code_r,
    input wire logic [13:0] group0_offset_dac_r,
    input wire logic [13:0] upper_groups_offset_dac_r,
    input wire logic thermal_shutdown_en_r,
    input wire logic soft_power_down_r
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_ctrl_wr; wr_en && reg_sel == 3'h5; endsequence
    sequence s_dac_quiet; ##3 $stable(dac_code_r); endsequence
    property p_pdown; s_ctrl_wr |-> ##2 soft_power_down_r == $past(wr_data[0], 2); endproperty
    a_pdown: assert property (p_pdown) else $error("power-down flag wrong");
    property p_therm; s_ctrl_wr |-> ##2 thermal_shutdown_en_r == $past(wr_data[1], 2); endproperty
    a_therm: assert property (p_therm) else $error("shutdown enable wrong");
    property p_ofs0w; wr_en && reg_sel == 3'h3 |=> group0_offset_dac_r == $past(wr_data[13:0]);
    endproperty
    a_ofs0w: assert property (p_ofs0w) else $error("group 0 offset not written");
    property p_ofs1w; wr_en && reg_sel == 3'h4 |=> upper_groups_offset_dac_r == $past(wr_data[13:0]);
    endproperty
    a_ofs1w: assert property (p_ofs1w) else $error("upper offset not written");
    property p_hold; load_converters_n |-> s_dac_quiet; endproperty
    a_hold: assert property (p_hold) else $error("converter codes moved without load");
    property p_rst; $fell(rst) |-> dac_code_r == '0 && group0_offset_dac_r == 14'h1555 &&
        upper_groups_offset_dac_r == 14'h1555 && !soft_power_down_r && !thermal_shutdown_en_r;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
    property p_ctrl_rd; rd_en && reg_sel == 3'h5 |=> rd_data_r[15:3] == 13'h0 &&
        rd_data_r[1:0] == {thermal_shutdown_en_r, soft_power_down_r}; endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");
    property p_upper_groups_offset_dac_rd; rd_en && reg_sel == 3'h4 |=> rd_data_r == {2'h0, $past(upper_groups_offset_dac_r)};
    endproperty
    a_upper_groups_offset_dac_rd: assert property (p_upper_groups_offset_dac_rd) else $error("upper offset readback wrong");
endmodule

bind mdr_core mdr_core_chk #(.NUM_GROUPS(NUM_GROUPS), .GROUP_SIZE(GROUP_SIZE)) u_chk (
    .core_clk(core_clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .reg_sel(reg_sel),
    .chan(chan), .wr_data(wr_data), .load_converters_n(load_converters_n), .rd_data_r(rd_data_r),
    .rd_valid_r(rd_valid_r), .dac_code_r(dac_code_r), .group0_offset_dac_r(group0_offset_dac_r),
    .upper_groups_offset_dac_r(upper_groups_offset_dac_r),
    .thermal_shutdown_en_r(thermal_shutdown_en_r), .soft_power_down_r(soft_power_down_r));

//--- verif/mdr_host.sv
`timescale 1ns/100ps
module mdr_host
(
    // Clock
    input wire logic core_clk,
    // Command side
    output logic wr_en,
    output logic rd_en,
    output logic [2:0] reg_sel,
    output logic [5:0] chan,
    output logic [15:0] wr_data,
    output logic load_converters_n,
    // Answer side
    input wire logic [15:0] rd_data_r,
    input wire logic rd_valid_r
);
    initial
    begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        reg_sel = 3'h0;
        chan = 6'h00;
        wr_data = 16'h0000;
        load_converters_n = 1'b1;
    end
    // Data is inverted once the strobe drops so a stale word never looks valid.
    task automatic wr(input logic [2:0] s, input logic [5:0] c, input logic [15:0] d);
        @(posedge core_clk);
        wr_en <= 1'b1;
        reg_sel <= s;
        chan <= c;
        wr_data <= d;
        @(posedge core_clk);
        wr_en <= 1'b0;
        wr_data <= ~d;
    endtask
    task automatic rd(input logic [2:0] s, input logic [5:0] c, output logic [15:0] d);
        int n;
        @(posedge core_clk);
        rd_en <= 1'b1;
        reg_sel <= s;
        chan <= c;
        @(posedge core_clk);
        rd_en <= 1'b0;
        for (n = 0; n < 4; n++)
        begin
            #1;
            if (rd_valid_r === 1'b1)
                break;
            @(posedge core_clk);
        end
        d = rd_data_r;
        if (n == 4)
        begin
            tb.fail_count++;
            tb.print_verdict();
        end
    endtask
    task automatic load(input int n);
        @(posedge core_clk);
        load_converters_n <= 1'b0;
        repeat (n) @(posedge core_clk);
        load_converters_n <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask
endmodule

//--- verif/tb.sv
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin fail_count++; \
    $display("BAD %s exp %h got %h", nm, (ex), (gt)); end end
module tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic wr_en, rd_en, rd_valid_r, load_converters_n, thermal_shutdown_en_r, soft_power_down_r;
    logic [2:0] reg_sel;
    logic [5:0] chan;
    logic [15:0] wr_data, rd_data_r, q;
    logic [639:0] dac_code_r;
    logic [13:0] group0_offset_dac_r, upper_groups_offset_dac_r;
    int fail_count = 0;
    int cmp_count = 0;
    always #20 core_clk = ~core_clk;
    mdr_core i_mdr_core (.core_clk(core_clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en),
        .reg_sel(reg_sel), .chan(chan), .wr_data(wr_data), .rd_data_r(rd_data_r),
        .rd_valid_r(rd_valid_r), .load_converters_n(load_converters_n), .dac_code_r(dac_code_r),
        .group0_offset_dac_r(group0_offset_dac_r),
        .upper_groups_offset_dac_r(upper_groups_offset_dac_r),
        .thermal_shutdown_en_r(thermal_shutdown_en_r), .soft_power_down_r(soft_power_down_r));
    mdr_host u_host (.core_clk(core_clk), .wr_en(wr_en), .rd_en(rd_en), .reg_sel(reg_sel),
        .chan(chan), .wr_data(wr_data), .load_converters_n(load_converters_n),
        .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r));
    function automatic logic [15:0] cal(input logic [15:0] d, input logic [15:0] g,
        input logic [15:0] o);
        logic [33:0] t;
        t = ((34'(d) * (34'(g) + 34'h1)) >> 16) + 34'(o);
        if (t < 34'h8000)
            return 16'h0000;
        t = t - 34'h8000;
        return (t > 34'hFFFF) ? 16'hFFFF : t[15:0];
    endfunction
    function automatic logic [15:0] dac(input int i);
        return dac_code_r[16*i +: 16];
    endfunction
    task automatic t_reset();
        #1;
        `CHK("dac", 640'h0, dac_code_r)
        u_host.rd(3'h0, 6'd39, q);
        `CHK("inA", 16'h1555, q)
        u_host.rd(3'h1, 6'd0, q);
        `CHK("gain", 16'h3FFF, q)
        u_host.rd(3'h2, 6'd20, q);
        `CHK("trim", 16'h2000, q)
        u_host.rd(3'h4, 6'd0, q);
        `CHK("upper_groups_offset_dac", 16'h1555, q)
        u_host.rd(3'h5, 6'd0, q);
        `CHK("ctrl", 16'h0000, q)
        u_host.rd(3'h6, 6'd4, q);
        `CHK("grp", 16'h0000, q)
        u_host.rd(3'h0, 6'd40, q);
        `CHK("range", 16'h0000, q)
    endtask
    task automatic t_bank();
        u_host.wr(3'h5, 6'd0, 16'h0004);
        u_host.rd(3'h0, 6'd5, q);
        `CHK("inB", 16'h1555, q)
        u_host.wr(3'h0, 6'd5, 16'hABCD);
        u_host.rd(3'h0, 6'd5, q);
        `CHK("wrB", 16'hABCD, q)
        u_host.wr(3'h5, 6'd0, 16'h0000);
        u_host.rd(3'h0, 6'd5, q);
        `CHK("keepA", 16'h1555, q)
    endtask
    // Control and offset registers, then a mid-run reset must clear the control bits.
    task automatic t_ctrl();
        u_host.wr(3'h3, 6'd0, 16'hEABC);
        u_host.wr(3'h4, 6'd0, 16'h0123);
        u_host.wr(3'h5, 6'd0, 16'h0003);
        u_host.rd(3'h3, 6'd0, q);
        `CHK("group0_offset_dac", 16'h2ABC, q)
        u_host.rd(3'h4, 6'd0, q);
        `CHK("ofs1w", 16'h0123, q)
        `CHK("therm", 1'b1, thermal_shutdown_en_r)
        `CHK("pdown", 1'b1, soft_power_down_r)
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        u_host.rd(3'h5, 6'd0, q);
        `CHK("ctrl0", 16'h0000, q)
    endtask
    task automatic t_cal();
        u_host.wr(3'h1, 6'd9, 16'hFFFF);
        u_host.wr(3'h2, 6'd9, 16'hFFFF);
        u_host.wr(3'h0, 6'd9, 16'hFFFF);
        u_host.wr(3'h1, 6'd11, 16'hFFFF);
        u_host.wr(3'h2, 6'd11, 16'h8000);
        u_host.wr(3'h0, 6'd11, 16'h8000);
        u_host.load(1);
        `CHK("sat", cal(16'hFFFF, 16'hFFFF, 16'hFFFF), dac(9))
        `CHK("low", cal(16'h1555, 16'h3FFF, 16'h2000), dac(0))
        `CHK("mid", cal(16'h8000, 16'hFFFF, 16'h8000), dac(11))
    endtask
    task automatic t_sel();
        u_host.wr(3'h5, 6'd0, 16'h0004);
        u_host.wr(3'h0, 6'd11, 16'h4000);
        u_host.wr(3'h5, 6'd0, 16'h0000);
        u_host.wr(3'h2, 6'd11, 16'h9000);
        u_host.wr(3'h6, 6'd1, 16'h0008);
        u_host.load(3);
        `CHK("selB", cal(16'h4000, 16'hFFFF, 16'h8000), dac(11))
        `CHK("selA", cal(16'hFFFF, 16'hFFFF, 16'hFFFF), dac(9))
        u_host.wr(3'h7, 6'd0, 16'h0000);
        u_host.load(2);
        `CHK("allA", cal(16'h8000, 16'hFFFF, 16'h9000), dac(11))
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_bank();
        t_ctrl();
        t_cal();
        t_sel();
        print_verdict();
    end
endmodule
